/* File: pkg/hobd_pkg.sv */
// Hub option byte layout, defaults and timing
package hobd_pkg;

	// Byte offsets of the option bytes in configuration space
	localparam logic [3:0] OFS_OPT_A = 4'h6;
	localparam logic [3:0] OFS_OPT_B = 4'h7;
	localparam logic [3:0] OFS_FIXED = 4'h8;
	localparam logic [3:0] OFS_SP_OFF = 4'h9;
	localparam logic [3:0] OFS_BP_OFF = 4'ha;

	// Field positions
	localparam int BIT_PWR_SEL = 7;
	localparam int BIT_HS_INH = 5;
	localparam int BIT_FEP_INH = 3;
	localparam int BIT_SNS_HI = 2;
	localparam int BIT_SNS_LO = 1;
	localparam int BIT_AUTO_SW = 7;
	localparam int BIT_DLY_HI = 5;
	localparam int BIT_DLY_LO = 4;
	localparam int BIT_COMPOUND = 3;
	localparam int BIT_PORT1 = 1;
	localparam int BIT_PORT2 = 2;

	// Reset values and writable bits
	localparam logic [7:0] RST_OPT_A_SELF = 8'h88;
	localparam logic [7:0] RST_OPT_A_BUS = 8'h0c;
	localparam logic [7:0] RST_OPT_B = 8'h90;
	localparam logic [1:0] RST_PORTS = 2'h0;
	localparam logic [7:0] WMASK_OPT_A = 8'hae;
	localparam logic [7:0] WMASK_OPT_B = 8'hb8;
	localparam logic [1:0] SNS_GANGED = 2'h0;
	localparam logic [1:0] SNS_RSVD = 2'h1;
	localparam logic [1:0] SETTLED = 2'h3;
	localparam logic [1:0] STRAP_TAKE = 2'h2;

	// Over-current delay times and their cycle counts
	localparam int CLK_PERIOD_NS = 50;
	localparam int OC_DLY0_US = 100;
	localparam int OC_DLY1_US = 2000;
	localparam int OC_DLY2_US = 4000;
	localparam int OC_DLY3_US = 6000;
	localparam int OC_DLY0_CYC = (OC_DLY0_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OC_DLY1_CYC = (OC_DLY1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OC_DLY2_CYC = (OC_DLY2_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OC_DLY3_CYC = (OC_DLY3_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OC_CNT_W = 17;

	typedef enum logic {LD_WAIT, LD_DONE} hobd_load_e;

	// Decoded control settings
	typedef struct packed {
		logic       self_powered;
		logic       high_speed_inhibit;
		logic       frame_end_pulse_inhibit;
		logic       oc_sense_on;
		logic       compound_device;
		logic [1:0] fixed_device_port_mask;
		logic [1:0] port_off;
		logic       attach_ok;
		logic       overcurrent;
		logic       config_conflict;
	} hobd_ctrl_s;

	// Top-level state
	typedef struct packed {
		logic [7:0] opt_a;
		logic [7:0] opt_b;
		logic [1:0] fixed;
		logic [1:0] sp_off;
		logic [1:0] bp_off;
		logic [1:0] pwr_sync;
		logic [1:0] oc_sync;
		logic [1:0] self_strap_sync;
		logic [1:0] mem_strap_sync;
		logic [1:0] settle;
		hobd_load_e ld;
		hobd_ctrl_s ctrl;
		logic [7:0] rdata;
	} hobd_top_s;

	// Over-current filter state
	typedef struct packed {
		logic [OC_CNT_W-1:0] cnt;
		logic                trip;
	} hobd_ocf_s;

endpackage : hobd_pkg

/* File: hw/hobd_oc_filter.sv */
`timescale 1ns/1ps
// Over-current qualification timer
module hobd_oc_filter (
	input  wire logic                          i_clk,
	input  wire logic                          i_srst,
	input  wire logic                          i_enable,
	input  wire logic                          i_active,
	input  wire logic [hobd_pkg::OC_CNT_W-1:0] i_delay_cycles,
	output logic                               o_tripped
);

	hobd_pkg::hobd_ocf_s s;
	hobd_pkg::hobd_ocf_s next_s;

	// Count while the fault is held; trip once the delay has run out
	always_comb begin
		next_s = s;
		if (!i_enable || !i_active) begin
			next_s = '0;
		end else if (s.cnt >= i_delay_cycles - 17'h00001) begin
			next_s.trip = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 17'h00001;
		end
		if (i_srst) begin
			next_s = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		s <= next_s;
	end

	assign o_tripped = s.trip;

	////////////////////////////////////////////////////////////////////////
	// Checks

	property p_trip_after_delay;
		@(posedge i_clk) disable iff (i_srst)
		$rose(s.trip) |-> $past(i_active) && $past(s.cnt) == i_delay_cycles - 17'h00001;
	endproperty
	a_trip_after_delay: assert property (p_trip_after_delay)
		else $error("trip before delay elapsed");

	property p_trip_drops;
		@(posedge i_clk) disable iff (i_srst)
		(!i_active || !i_enable) |=> !s.trip && s.cnt == '0;
	endproperty
	a_trip_drops: assert property (p_trip_drops)
		else $error("trip held without fault");

endmodule : hobd_oc_filter

/* File: hw/hobd_option_decoder.sv */
`timescale 1ns/1ps
//
// Summary of operation
// - Option byte A bit 7 selects power mode: 0 bus, 1 self.
// - With auto switching on, the local power pin sets the power mode.
// - Option byte A bit 5 set forces full-speed-only attachment.
// - Option byte A bit 3 set suppresses end-of-packet at EOF1; 0 enables.
// - Bits 2:1: 00 ganged sensing, 01 reserved, 1x none (bus power only).
// - Option byte B bit 7 enables automatic power-source switching.
// - Option byte B bits 5:4 pick over-current delay 0.1, 2, 4, 6 ms.
// - Option byte B bit 3 marks the hub part of a compound device.
// - Fixed-device byte bits 1 and 2 mark ports non-removable.
// - Self-power port-off byte disables ports 1 and 2 in self power.
// - Bus-power port-off byte disables ports 1 and 2 in bus power.
// - In memory setup mode, attach only after all bytes are fetched.
//
module hobd_option_decoder #(
	parameter int P_OC_DLY1_CYC = hobd_pkg::OC_DLY1_CYC,
	parameter int P_OC_DLY2_CYC = hobd_pkg::OC_DLY2_CYC,
	parameter int P_OC_DLY3_CYC = hobd_pkg::OC_DLY3_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic        i_cfg_wr,
	input  wire logic [3:0]  i_cfg_addr,
	input  wire logic [7:0]  i_cfg_wdata,
	input  wire logic        i_load_done,
	input  wire logic        i_local_power_present_pin,
	input  wire logic        i_overcurrent_n,
	input  wire logic        i_default_self_strap,
	input  wire logic        i_mem_setup_strap,
	output logic [7:0]       o_cfg_rdata,
	output hobd_pkg::hobd_ctrl_s o_ctrl
);

	hobd_pkg::hobd_top_s s;
	hobd_pkg::hobd_top_s next_s;
	logic                          oc_trip;
	logic [hobd_pkg::OC_CNT_W-1:0] oc_delay;

	// Keep the two port bits of a mask byte
	function automatic logic [1:0] hobd_ports(input logic [7:0] b);
		return {b[hobd_pkg::BIT_PORT2], b[hobd_pkg::BIT_PORT1]};
	endfunction : hobd_ports

	// Rebuild a mask byte; reserved bits read as zero
	function automatic logic [7:0] hobd_mask_byte(input logic [1:0] m);
		return {5'h00, m, 1'b0};
	endfunction : hobd_mask_byte

	////////////////////////////////////////////////////////////////////////
	// Delay selection for the over-current timer

	always_comb begin
		case (s.opt_b[hobd_pkg::BIT_DLY_HI:hobd_pkg::BIT_DLY_LO])
			2'h0: oc_delay = hobd_pkg::OC_CNT_W'(hobd_pkg::OC_DLY0_CYC);
			2'h1: oc_delay = hobd_pkg::OC_CNT_W'(P_OC_DLY1_CYC);
			2'h2: oc_delay = hobd_pkg::OC_CNT_W'(P_OC_DLY2_CYC);
			default: oc_delay = hobd_pkg::OC_CNT_W'(P_OC_DLY3_CYC);
		endcase
	end

	hobd_oc_filter u_oc_filter (
		.i_clk          (i_clk),
		.i_srst         (i_srst),
		.i_enable       (s.ctrl.oc_sense_on),
		.i_active       (s.oc_sync[1]),
		.i_delay_cycles (oc_delay),
		.o_tripped      (oc_trip)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic       self_now;
		logic [1:0] sns;
		self_now = 1'b0;
		sns = 2'h0;
		next_s = s;
		// Pin synchronisers
		next_s.pwr_sync = {s.pwr_sync[0], i_local_power_present_pin};
		next_s.oc_sync = {s.oc_sync[0], ~i_overcurrent_n};
		next_s.self_strap_sync = {s.self_strap_sync[0], i_default_self_strap};
		next_s.mem_strap_sync = {s.mem_strap_sync[0], i_mem_setup_strap};
		if (s.settle != hobd_pkg::SETTLED) begin
			next_s.settle = s.settle + 2'h1;
		end
		// Strap picks the self or bus default once the straps are stable
		if (s.settle == hobd_pkg::STRAP_TAKE) begin
			next_s.opt_a = s.self_strap_sync[1] ? hobd_pkg::RST_OPT_A_SELF
				: hobd_pkg::RST_OPT_A_BUS;
			if (!s.mem_strap_sync[1]) begin
				next_s.ld = hobd_pkg::LD_DONE;
			end
		end
		// Byte writes from the memory fetch or the management port
		if (i_cfg_wr) begin
			if (i_cfg_addr == hobd_pkg::OFS_OPT_A) begin
				next_s.opt_a = i_cfg_wdata & hobd_pkg::WMASK_OPT_A;
			end else if (i_cfg_addr == hobd_pkg::OFS_OPT_B) begin
				next_s.opt_b = i_cfg_wdata & hobd_pkg::WMASK_OPT_B;
			end else if (i_cfg_addr == hobd_pkg::OFS_FIXED) begin
				next_s.fixed = hobd_ports(i_cfg_wdata);
			end else if (i_cfg_addr == hobd_pkg::OFS_SP_OFF) begin
				next_s.sp_off = hobd_ports(i_cfg_wdata);
			end else if (i_cfg_addr == hobd_pkg::OFS_BP_OFF) begin
				next_s.bp_off = hobd_ports(i_cfg_wdata);
			end
		end
		// Attach waits for the fetch to finish in memory setup mode
		if (i_load_done && s.settle == hobd_pkg::SETTLED) begin
			next_s.ld = hobd_pkg::LD_DONE;
		end
		// Register read data
		if (i_cfg_addr == hobd_pkg::OFS_OPT_A) begin
			next_s.rdata = s.opt_a;
		end else if (i_cfg_addr == hobd_pkg::OFS_OPT_B) begin
			next_s.rdata = s.opt_b;
		end else if (i_cfg_addr == hobd_pkg::OFS_FIXED) begin
			next_s.rdata = hobd_mask_byte(s.fixed);
		end else if (i_cfg_addr == hobd_pkg::OFS_SP_OFF) begin
			next_s.rdata = hobd_mask_byte(s.sp_off);
		end else if (i_cfg_addr == hobd_pkg::OFS_BP_OFF) begin
			next_s.rdata = hobd_mask_byte(s.bp_off);
		end else begin
			next_s.rdata = 8'h00;
		end
		// Power mode: the pin rules when auto switching is on
		if (next_s.opt_b[hobd_pkg::BIT_AUTO_SW]) begin
			self_now = s.pwr_sync[1];
		end else begin
			self_now = next_s.opt_a[hobd_pkg::BIT_PWR_SEL];
		end
		sns = next_s.opt_a[hobd_pkg::BIT_SNS_HI:hobd_pkg::BIT_SNS_LO];
		next_s.ctrl.self_powered = self_now;
		next_s.ctrl.high_speed_inhibit = next_s.opt_a[hobd_pkg::BIT_HS_INH];
		next_s.ctrl.frame_end_pulse_inhibit = next_s.opt_a[hobd_pkg::BIT_FEP_INH];
		// Only the ganged code senses; reserved or no-sense on self power is flagged
		next_s.ctrl.oc_sense_on = (sns == hobd_pkg::SNS_GANGED);
		next_s.ctrl.config_conflict = (sns == hobd_pkg::SNS_RSVD) || (sns[1] && self_now);
		next_s.ctrl.compound_device = next_s.opt_b[hobd_pkg::BIT_COMPOUND];
		next_s.ctrl.fixed_device_port_mask = next_s.fixed;
		next_s.ctrl.port_off = self_now ? next_s.sp_off : next_s.bp_off;
		next_s.ctrl.attach_ok = (next_s.ld == hobd_pkg::LD_DONE);
		next_s.ctrl.overcurrent = oc_trip && next_s.ctrl.oc_sense_on;
		// Synchronous reset to the bus-power defaults
		if (i_srst) begin
			next_s = '0;
			next_s.opt_a = hobd_pkg::RST_OPT_A_BUS;
			next_s.opt_b = hobd_pkg::RST_OPT_B;
			next_s.fixed = hobd_pkg::RST_PORTS;
			next_s.sp_off = hobd_pkg::RST_PORTS;
			next_s.bp_off = hobd_pkg::RST_PORTS;
			next_s.ld = hobd_pkg::LD_WAIT;
		end
	end

	always_ff @(posedge i_clk) begin
		s <= next_s;
	end

	assign o_ctrl = s.ctrl;
	assign o_cfg_rdata = s.rdata;

	////////////////////////////////////////////////////////////////////////
	// Checks

	property p_pwr_select;
		@(posedge i_clk) disable iff (i_srst)
		(s.settle != 2'h0 && !s.opt_b[hobd_pkg::BIT_AUTO_SW])
			|-> s.ctrl.self_powered == s.opt_a[hobd_pkg::BIT_PWR_SEL];
	endproperty
	a_pwr_select: assert property (p_pwr_select)
		else $error("power mode not from select bit");

	property p_auto_pin;
		@(posedge i_clk) disable iff (i_srst)
		(s.settle != 2'h0 && s.opt_b[hobd_pkg::BIT_AUTO_SW])
			|-> s.ctrl.self_powered == $past(s.pwr_sync[1]);
	endproperty
	a_auto_pin: assert property (p_auto_pin)
		else $error("auto mode ignores power pin");

	property p_hs_inh;
		@(posedge i_clk) disable iff (i_srst)
		s.settle != 2'h0 |-> s.ctrl.high_speed_inhibit == s.opt_a[hobd_pkg::BIT_HS_INH];
	endproperty
	a_hs_inh: assert property (p_hs_inh)
		else $error("high speed inhibit mismatch");

	property p_fep_inh;
		@(posedge i_clk) disable iff (i_srst)
		s.settle != 2'h0 |-> s.ctrl.frame_end_pulse_inhibit == s.opt_a[hobd_pkg::BIT_FEP_INH];
	endproperty
	a_fep_inh: assert property (p_fep_inh)
		else $error("frame end pulse inhibit mismatch");

	property p_sense;
		@(posedge i_clk) disable iff (i_srst)
		s.settle != 2'h0 |-> s.ctrl.oc_sense_on
			== (s.opt_a[hobd_pkg::BIT_SNS_HI:hobd_pkg::BIT_SNS_LO] == hobd_pkg::SNS_GANGED)
			&& (!s.ctrl.overcurrent || s.ctrl.oc_sense_on);
	endproperty
	a_sense: assert property (p_sense)
		else $error("sense scheme decode wrong");

	property p_no_auto_hold;
		@(posedge i_clk) disable iff (i_srst)
		(s.settle == hobd_pkg::SETTLED && !s.opt_b[hobd_pkg::BIT_AUTO_SW] && !i_cfg_wr)
			|=> $stable(s.ctrl.self_powered);
	endproperty
	a_no_auto_hold: assert property (p_no_auto_hold)
		else $error("power mode moved without auto switching");

	property p_compound;
		@(posedge i_clk) disable iff (i_srst)
		s.settle != 2'h0 |-> s.ctrl.compound_device == s.opt_b[hobd_pkg::BIT_COMPOUND];
	endproperty
	a_compound: assert property (p_compound)
		else $error("compound flag mismatch");

	property p_mask_read;
		@(posedge i_clk) disable iff (i_srst)
		(i_cfg_addr >= hobd_pkg::OFS_FIXED && i_cfg_addr <= hobd_pkg::OFS_BP_OFF)
			|=> o_cfg_rdata[7:3] == 5'h00 && !o_cfg_rdata[0];
	endproperty
	a_mask_read: assert property (p_mask_read)
		else $error("reserved mask bits read nonzero");

	property p_port_off;
		@(posedge i_clk) disable iff (i_srst)
		s.settle != 2'h0 |-> s.ctrl.port_off == (s.ctrl.self_powered ? s.sp_off : s.bp_off);
	endproperty
	a_port_off: assert property (p_port_off)
		else $error("port-off mask not from active mode");

	property p_attach;
		@(posedge i_clk) disable iff (i_srst)
		(s.mem_strap_sync[1] && s.settle == hobd_pkg::SETTLED && s.ld == hobd_pkg::LD_WAIT)
			|-> (!s.ctrl.attach_ok and (i_load_done |=> s.ctrl.attach_ok));
	endproperty
	a_attach: assert property (p_attach)
		else $error("attach before fetch complete");

	c_auto_switch: cover property (@(posedge i_clk) disable iff (i_srst)
		s.opt_b[7] && $changed(s.ctrl.self_powered));
	c_overcurrent: cover property (@(posedge i_clk) disable iff (i_srst)
		$rose(s.ctrl.overcurrent));
	c_attach: cover property (@(posedge i_clk) disable iff (i_srst)
		$rose(s.ctrl.attach_ok));

endmodule : hobd_option_decoder

/* File: dv/hobd_cfg_mem.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Configuration memory that streams offsets 6..b, then flags the fetch done
module hobd_cfg_mem (
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic        i_start,
	input  wire logic [47:0] i_img,
	input  wire logic [3:0]  i_rd_addr,
	output logic             o_cfg_wr,
	output logic [3:0]       o_cfg_addr,
	output logic [7:0]       o_cfg_wdata,
	output logic             o_load_done
);
	logic [2:0] idx;
	logic       busy;
	logic [7:0] cur;
	// Port mask bytes keep reserved bits clear; two ports are always contiguous
	always_comb begin
		cur = i_img[idx*8 +: 8];
		if (idx >= 3'h2 && idx <= 3'h4) begin
			cur = cur & 8'h06;
		end
	end
	// Idle bus shows the inverse of the data so stale values never match
	assign o_cfg_wr    = busy;
	assign o_cfg_addr  = busy ? 4'h6 + {1'b0, idx} : i_rd_addr;
	assign o_cfg_wdata = busy ? cur : ~cur;
	// One byte per cycle; completion pulse after the last byte
	always_ff @(posedge i_clk) begin
		o_load_done <= 1'b0;
		if (i_srst) begin
			busy <= 1'b0;
			idx  <= 3'h0;
		end else if (i_start) begin
			busy <= 1'b1;
			idx  <= 3'h0;
		end else if (busy) begin
			idx <= idx + 3'h1;
			if (idx == 3'h5) begin
				busy        <= 1'b0;
				o_load_done <= 1'b1;
			end
		end
	end
endmodule : hobd_cfg_mem

/* File: dv/hub_option_byte_decoder_tb.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module hub_option_byte_decoder_tb;
	logic                 i_clk, i_srst, start, pin, ocn, sstrap, mstrap, wr, ld, att, oc;
	logic [47:0]          img, rimg;
	logic [3:0]           rd_addr, addr;
	logic [7:0]           wdata, rdata;
	logic [7:0]           st[6];
	logic [31:0]          lfsr;
	hobd_pkg::hobd_ctrl_s ctrl;
	int                   n_fail, samples_checked, cycles, i, k;
	int                   dly[4] = '{hobd_pkg::OC_DLY0_CYC, 20, 40, 60};

	hobd_cfg_mem mem_u (.i_clk(i_clk), .i_srst(i_srst), .i_start(start), .i_img(img),
		.i_rd_addr(rd_addr), .o_cfg_wr(wr), .o_cfg_addr(addr), .o_cfg_wdata(wdata),
		.o_load_done(ld));
	hobd_option_decoder #(.P_OC_DLY1_CYC(20), .P_OC_DLY2_CYC(40), .P_OC_DLY3_CYC(60)) dut_u (
		.i_clk(i_clk), .i_srst(i_srst), .i_cfg_wr(wr), .i_cfg_addr(addr),
		.i_cfg_wdata(wdata), .i_load_done(ld), .i_local_power_present_pin(pin),
		.i_overcurrent_n(ocn), .i_default_self_strap(sstrap), .i_mem_setup_strap(mstrap),
		.o_cfg_rdata(rdata), .o_ctrl(ctrl));

	////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			$display("ERROR %0t timeout", $time);
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////
	// Reference model of the decoded settings
	function automatic hobd_pkg::hobd_ctrl_s model();
		hobd_pkg::hobd_ctrl_s c;
		c = '0;
		c.self_powered            = st[1][7] ? pin : st[0][7];
		c.high_speed_inhibit      = st[0][5];
		c.frame_end_pulse_inhibit = st[0][3];
		c.oc_sense_on             = (st[0][2:1] == 2'h0);
		c.compound_device         = st[1][3];
		c.fixed_device_port_mask  = st[2][2:1];
		c.port_off                = c.self_powered ? st[3][2:1] : st[4][2:1];
		c.attach_ok               = att;
		c.overcurrent             = oc;
		c.config_conflict         = (st[0][2:1] == 2'h1) || (st[0][2] && c.self_powered);
		return c;
	endfunction : model

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next

	////////////////////////////////////////////////////////////////
	// Waits, checks and transfers
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cyc

	task automatic chk_ctrl();
		samples_checked++;
		if (ctrl !== model()) begin
			n_fail++;
			$display("ERROR %0t ctrl %h exp %h", $time, ctrl, model());
		end
	endtask : chk_ctrl

	task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_clk);
		rd_addr <= a;
		cyc(2);
		samples_checked++;
		if (rdata !== e) begin
			n_fail++;
			$display("ERROR %0t read %h got %h exp %h", $time, a, rdata, e);
		end
	endtask : chk_rd

	task automatic chk_all();
		for (k = 0; k < 6; k++) begin
			chk_rd(4'h6 + k[3:0], st[k]);
		end
	endtask : chk_all

	task automatic do_reset(input logic s, input logic m);
		@(posedge i_clk);
		i_srst <= 1'b1;
		sstrap <= s;
		mstrap <= m;
		cyc(20);
		@(posedge i_clk);
		i_srst <= 1'b0;
		cyc(6);
		st  = '{s ? 8'h88 : 8'h0c, 8'h90, 8'h00, 8'h00, 8'h00, 8'h00};
		att = !m;
	endtask : do_reset

	task automatic load(input logic [47:0] v);
		@(posedge i_clk);
		img   <= v;
		start <= 1'b1;
		@(posedge i_clk);
		start <= 1'b0;
		for (k = 0; k < 20 && ld !== 1'b1; k++) cyc(1);
		if (ld !== 1'b1) begin
			n_fail++;
			$display("ERROR %0t fetch never completed", $time);
		end
		cyc(4);
		st  = '{v[7:0] & 8'hae, v[15:8] & 8'hb8, v[23:16] & 8'h06, v[31:24] & 8'h06,
			v[39:32] & 8'h06, 8'h00};
		att = 1'b1;
	endtask : load

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{start, sstrap, mstrap, att, oc} = '0;
		i_srst = 1'b1;
		{pin, ocn} = 2'h3;
		img = '0;
		rd_addr = 4'h0;
		lfsr = 32'h684d;
		do_reset(1'b0, 1'b0);
		chk_ctrl();
		chk_all();
		$display("test defaults done");
		do_reset(1'b1, 1'b1);
		chk_ctrl();
		chk_rd(4'h6, 8'h88);
		$display("test memory setup done");
		// Random images with forced field corners, then a random pin level
		for (i = 0; i < 16; i++) begin
			lfsr = lfsr_next(lfsr);
			rimg = {lfsr[15:0], lfsr};
			rimg[2:1] = i[1:0];
			rimg[15]  = i[2];
			rimg[7]   = i[3];
			load(rimg);
			chk_ctrl();
			@(posedge i_clk);
			pin <= lfsr[9];
			cyc(5);
			chk_ctrl();
			chk_all();
		end
		$display("test random images done");
		// Over-current delay per code, ganged sensing in bus power; then no sensing ignores the fault
		for (i = 0; i < 4; i++) begin
			load({32'h0, 2'h0, i[1:0], 4'h0, 8'h00});
			@(posedge i_clk);
			ocn <= 1'b0;
			cyc(dly[i]);
			chk_ctrl();
			oc = 1'b1;
			cyc(6);
			chk_ctrl();
			@(posedge i_clk);
			ocn <= 1'b1;
			oc = 1'b0;
			cyc(5);
			chk_ctrl();
		end
		load({32'h0, 8'h10, 8'h04});
		@(posedge i_clk);
		ocn <= 1'b0;
		cyc(100);
		chk_ctrl();
		$display("test overcurrent done");
		finish_test();
	end

	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
endmodule : hub_option_byte_decoder_tb
